// File: hw/dtcu_timer_unit.sv
// Dual timer/counter unit with mode and run/flag registers
`timescale 1ns/1ps
`default_nettype none
module dtcu_timer_unit #(
    parameter int MC_LEN = dtcu_pkg::MACHINE_CYCLE_CLOCKS
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire dtcu_pkg::dtcu_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire logic count_pin_zero,
    input wire logic count_pin_one,
    input wire logic gate_pin_zero,
    input wire logic gate_pin_one,
    input wire logic isr_ack_zero,
    input wire logic isr_ack_one,
    output logic timer_zero_overflow_flag,
    output logic timer_one_overflow_flag
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (MC_LEN < 12 || MC_LEN > 16) begin : g_bad_len
        $error("MC_LEN must lie between 12 and 16");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [3:0] phase_q;
    logic sample_stb;
    logic tick;
    logic [7:0] mode_q;
    logic run_zero_q;
    logic run_one_q;
    logic flag_zero_q;
    logic flag_one_q;
    dtcu_pkg::dtcu_count_t cnt0_q;
    dtcu_pkg::dtcu_count_t cnt1_q;
    dtcu_pkg::dtcu_count_t cnt0_d;
    dtcu_pkg::dtcu_count_t cnt1_d;
    dtcu_pkg::dtcu_cfg_t cfg0;
    dtcu_pkg::dtcu_cfg_t cfg1;
    logic [7:0] rdata_q;
    logic [1:0] pend_q;
    logic [1:0] fall;
    logic gate0_lvl;
    logic gate1_lvl;
    logic split0;
    logic run0;
    logic run1;
    logic inc0;
    logic inc1;
    logic inc0_high;
    logic ovf0;
    logic ovf0_high;
    logic ovf1;
    logic set_flag_zero;
    logic set_flag_one;
    logic wr_run_flag;
    logic wr_mode;

    assign cfg0 = dtcu_pkg::dtcu_cfg_t'(mode_q[3:0]);
    assign cfg1 = dtcu_pkg::dtcu_cfg_t'(mode_q[7:4]);
    assign split0 = (cfg0.mode == dtcu_pkg::MODE_SPLIT);
    assign wr_run_flag = sfr_req.wr && (sfr_req.addr == dtcu_pkg::ADDR_RUN_FLAG);
    assign wr_mode = sfr_req.wr && (sfr_req.addr == dtcu_pkg::ADDR_MODE);

    // ------------------------------------------------------------
    // Machine cycle phase counter
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_q <= 4'h0;
        end else if (phase_q == 4'(MC_LEN - 1)) begin
            phase_q <= 4'h0;
        end else begin
            phase_q <= phase_q + 4'h1;
        end
    end

    assign sample_stb = (phase_q == dtcu_pkg::SAMPLE_PHASE);
    assign tick = (phase_q == dtcu_pkg::UPDATE_PHASE);

    // ------------------------------------------------------------
    // External pins
    // ------------------------------------------------------------
    dtcu_pin_sampler u_count_zero (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(count_pin_zero),
        .sample_stb(sample_stb),
        .level(),
        .fall(fall[0])
    );

    dtcu_pin_sampler u_count_one (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(count_pin_one),
        .sample_stb(sample_stb),
        .level(),
        .fall(fall[1])
    );

    dtcu_pin_sampler u_gate_zero (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(gate_pin_zero),
        .sample_stb(sample_stb),
        .level(gate0_lvl),
        .fall()
    );

    dtcu_pin_sampler u_gate_one (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin(gate_pin_one),
        .sample_stb(sample_stb),
        .level(gate1_lvl),
        .fall()
    );

    // Detected fall waits for the next update phase
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_q <= 2'b00;
        end else begin
            pend_q <= fall | (pend_q & ~{2{tick}});
        end
    end

    // ------------------------------------------------------------
    // Count enables
    // ------------------------------------------------------------
    assign run0 = run_zero_q && (!cfg0.gate || gate0_lvl);
    assign inc0 = tick && run0 && (cfg0.src ? pend_q[0] : 1'b1);
    // Split mode high byte counts machine cycles on timer one's run bit
    assign inc0_high = tick && split0 && run_one_q;
    // Timer one free of its run bit while timer zero borrows it
    assign run1 = (split0 || run_one_q) && (!cfg1.gate || gate1_lvl);
    assign inc1 = tick && run1 && (cfg1.mode != dtcu_pkg::MODE_SPLIT)
        && (cfg1.src ? pend_q[1] : 1'b1);

    // ------------------------------------------------------------
    // Count step per mode
    // ------------------------------------------------------------
    function automatic dtcu_pkg::dtcu_step_t step(
        input dtcu_pkg::dtcu_mode_t mode,
        input dtcu_pkg::dtcu_count_t cnt
    );
        dtcu_pkg::dtcu_step_t res;
        res.count = cnt;
        res.ovf = 1'b0;
        unique case (mode)
            dtcu_pkg::MODE_PRESCALED: begin
                // Upper three low bits left alone
                res.count.low[4:0] = cnt.low[4:0] + 5'h01;
                if (&cnt.low[4:0]) begin
                    res.count.high = cnt.high + 8'h01;
                    res.ovf = &cnt.high;
                end
            end
            dtcu_pkg::MODE_WIDE: begin
                {res.ovf, res.count} = {1'b0, cnt} + 17'h0_0001;
            end
            dtcu_pkg::MODE_RELOAD: begin
                if (&cnt.low) begin
                    res.count.low = cnt.high;
                    res.ovf = 1'b1;
                end else begin
                    res.count.low = cnt.low + 8'h01;
                end
            end
            dtcu_pkg::MODE_SPLIT: begin
                res.count.low = cnt.low + 8'h01;
                res.ovf = &cnt.low;
            end
        endcase
        return res;
    endfunction

    always_comb begin
        dtcu_pkg::dtcu_step_t s0;
        dtcu_pkg::dtcu_step_t s1;
        s0 = step(cfg0.mode, cnt0_q);
        s1 = step(cfg1.mode, cnt1_q);
        cnt0_d = cnt0_q;
        cnt1_d = cnt1_q;
        ovf0 = 1'b0;
        ovf0_high = 1'b0;
        ovf1 = 1'b0;
        if (inc0) begin
            cnt0_d = s0.count;
            ovf0 = s0.ovf;
        end
        if (inc0_high) begin
            cnt0_d.high = cnt0_q.high + 8'h01;
            ovf0_high = &cnt0_q.high;
        end
        if (inc1) begin
            cnt1_d = s1.count;
            ovf1 = s1.ovf;
        end
        // Software byte writes override hardware in the same cycle
        if (sfr_req.wr) begin
            unique case (sfr_req.addr)
                dtcu_pkg::ADDR_ZERO_LOW: cnt0_d.low = sfr_req.wdata;
                dtcu_pkg::ADDR_ZERO_HIGH: cnt0_d.high = sfr_req.wdata;
                dtcu_pkg::ADDR_ONE_LOW: cnt1_d.low = sfr_req.wdata;
                dtcu_pkg::ADDR_ONE_HIGH: cnt1_d.high = sfr_req.wdata;
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Count registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt0_q <= {dtcu_pkg::RESET_COUNT, dtcu_pkg::RESET_COUNT};
            cnt1_q <= {dtcu_pkg::RESET_COUNT, dtcu_pkg::RESET_COUNT};
        end else begin
            cnt0_q <= cnt0_d;
            cnt1_q <= cnt1_d;
        end
    end

    // ------------------------------------------------------------
    // Mode register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mode_q <= dtcu_pkg::RESET_MODE;
        end else if (wr_mode) begin
            mode_q <= sfr_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // Run and flag register; hardware set wins over any clear
    // ------------------------------------------------------------
    assign set_flag_zero = ovf0;
    assign set_flag_one = split0 ? ovf0_high : ovf1;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            run_zero_q <= dtcu_pkg::RESET_RUN_FLAG[dtcu_pkg::BIT_ZERO_RUN];
            run_one_q <= dtcu_pkg::RESET_RUN_FLAG[dtcu_pkg::BIT_ONE_RUN];
            flag_zero_q <= dtcu_pkg::RESET_RUN_FLAG[dtcu_pkg::BIT_ZERO_FLAG];
            flag_one_q <= dtcu_pkg::RESET_RUN_FLAG[dtcu_pkg::BIT_ONE_FLAG];
        end else begin
            if (wr_run_flag) begin
                run_zero_q <= sfr_req.wdata[dtcu_pkg::BIT_ZERO_RUN];
                run_one_q <= sfr_req.wdata[dtcu_pkg::BIT_ONE_RUN];
            end
            if (set_flag_zero) begin
                flag_zero_q <= 1'b1;
            end else if (wr_run_flag) begin
                flag_zero_q <= sfr_req.wdata[dtcu_pkg::BIT_ZERO_FLAG];
            end else if (isr_ack_zero) begin
                flag_zero_q <= 1'b0;
            end
            if (set_flag_one) begin
                flag_one_q <= 1'b1;
            end else if (wr_run_flag) begin
                flag_one_q <= sfr_req.wdata[dtcu_pkg::BIT_ONE_FLAG];
            end else if (isr_ack_one) begin
                flag_one_q <= 1'b0;
            end
        end
    end

    assign timer_zero_overflow_flag = flag_zero_q;
    assign timer_one_overflow_flag = flag_one_q;

    // ------------------------------------------------------------
    // Read data, one cycle after the address
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else begin
            unique case (sfr_req.addr)
                dtcu_pkg::ADDR_RUN_FLAG: rdata_q <= {flag_one_q, run_one_q,
                    flag_zero_q, run_zero_q, 4'h0};
                dtcu_pkg::ADDR_MODE: rdata_q <= mode_q;
                dtcu_pkg::ADDR_ZERO_LOW: rdata_q <= cnt0_q.low;
                dtcu_pkg::ADDR_ZERO_HIGH: rdata_q <= cnt0_q.high;
                dtcu_pkg::ADDR_ONE_LOW: rdata_q <= cnt1_q.low;
                dtcu_pkg::ADDR_ONE_HIGH: rdata_q <= cnt1_q.high;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    assign sfr_rdata = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic wr_cnt0;
    assign wr_cnt0 = sfr_req.wr && (sfr_req.addr == dtcu_pkg::ADDR_ZERO_LOW
        || sfr_req.addr == dtcu_pkg::ADDR_ZERO_HIGH);

    phase_wrap_a: assert property (phase_q == 4'(MC_LEN - 1) |=> phase_q == 4'h0 ##4 tick)
        else $error("Machine cycle phase did not wrap");
    update_phase_a: assert property (inc0 || inc1 |-> phase_q == dtcu_pkg::UPDATE_PHASE)
        else $error("Count advanced outside update phase");
    fall_timing_a: assert property (fall[0] |-> $past(sample_stb) ##[1:7] tick)
        else $error("Fall not consumed at next update phase");
    timer_count_a: assert property (cfg0.mode == dtcu_pkg::MODE_WIDE && !cfg0.src
        && run0 && tick && !wr_cnt0 |=> cnt0_q == $past(cnt0_q) + 16'h0001)
        else $error("Sixteen-bit timer did not advance by one");
    edge_count_a: assert property (cfg0.src && run0 && pend_q[0] && tick
        && cfg0.mode == dtcu_pkg::MODE_WIDE && !wr_cnt0 |=> cnt0_q == $past(cnt0_q) + 16'h0001)
        else $error("Counted edge did not advance the count");
    gate_zero_a: assert property (cfg0.gate && !gate0_lvl |-> !inc0)
        else $error("Timer zero counted with gate low");
    gate_one_a: assert property (cfg1.gate && !gate1_lvl |-> !inc1)
        else $error("Timer one counted with gate low");
    stop_one_a: assert property (cfg1.mode == dtcu_pkg::MODE_SPLIT && !sfr_req.wr
        |=> $stable(cnt1_q))
        else $error("Timer one moved in stop mode");
    reload_a: assert property (cfg0.mode == dtcu_pkg::MODE_RELOAD && inc0 && &cnt0_q.low
        && !wr_cnt0 |=> cnt0_q.low == $past(cnt0_q.high) && flag_zero_q)
        else $error("Reload or flag missing on overflow");
    prescale_a: assert property (cfg0.mode == dtcu_pkg::MODE_PRESCALED && inc0
        && !(&cnt0_q.low[4:0]) && !wr_cnt0 |=> $stable(cnt0_q.high))
        else $error("High byte moved before prescaler wrapped");
    run_hold_a: assert property (!run_zero_q && !split0 && !wr_cnt0 |=> $stable(cnt0_q))
        else $error("Stopped timer zero changed");
    ack_clear_a: assert property (isr_ack_zero && !set_flag_zero && !wr_run_flag
        |=> !flag_zero_q)
        else $error("Acknowledge did not clear flag");
    write_wins_a: assert property (sfr_req.wr && sfr_req.addr == dtcu_pkg::ADDR_ZERO_LOW
        |=> cnt0_q.low == $past(sfr_req.wdata))
        else $error("Byte write lost to hardware update");

    wrap_cover_c: cover property (ovf0 ##1 flag_zero_q);
    split_cover_c: cover property (split0 && ovf0_high);
    edge_cover_c: cover property (cfg1.src && inc1);

endmodule
`default_nettype wire

// File: include/dtcu_pkg.sv
// Constants and types for the dual timer/counter unit
// Behaviour
// - Each timer holds high and low count bytes
// - Timer function counts once per twelve-clock machine cycle
// - Count pin sampled at sample phase; high-then-low counts
// - Counted edge appears at next update phase
// - Edge recognition takes two machine cycles
// - Timer one gate bit needs gate pin high
// - Timer zero gate bit needs gate pin high
// - Timer one source bit selects count pin
// - Timer zero source bit selects count pin
// - Mode 00: high byte counts, low five-bit prescaler
// - Mode 01: bytes cascade into sixteen-bit counter
// - Mode 10: low byte reloads from high byte
// - Mode 11 stops timer one, holding value
// - Timer zero mode 11 splits into two counters
// - Mode register nibbles per timer, resets zero
// - Overflow sets flag; vector acknowledge clears it
// - Run bit written by software starts or stops
// - Thirteen-bit mode ignores upper three low bits
// - Setting run bit leaves counts untouched
package dtcu_pkg;

    // ------------------------------------------------------------
    // Register offsets on the special function register bus
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RUN_FLAG = 8'h88;
    localparam logic [7:0] ADDR_MODE = 8'h89;
    localparam logic [7:0] ADDR_ZERO_LOW = 8'h8A;
    localparam logic [7:0] ADDR_ONE_LOW = 8'h8B;
    localparam logic [7:0] ADDR_ZERO_HIGH = 8'h8C;
    localparam logic [7:0] ADDR_ONE_HIGH = 8'h8D;

    // ------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] RESET_RUN_FLAG = 8'h00;
    localparam logic [7:0] RESET_MODE = 8'h00;
    localparam logic [7:0] RESET_COUNT = 8'h00;
    localparam int BIT_ONE_FLAG = 7;
    localparam int BIT_ONE_RUN = 6;
    localparam int BIT_ZERO_FLAG = 5;
    localparam int BIT_ZERO_RUN = 4;
    localparam int PRESCALE_BITS = 5;

    // ------------------------------------------------------------
    // Machine cycle timing in core clocks
    // ------------------------------------------------------------
    localparam int MACHINE_CYCLE_CLOCKS = 12;
    localparam logic [3:0] UPDATE_PHASE = 4'h4;
    localparam logic [3:0] SAMPLE_PHASE = 4'h9;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_PRESCALED = 2'b00,
        MODE_WIDE = 2'b01,
        MODE_RELOAD = 2'b10,
        MODE_SPLIT = 2'b11
    } dtcu_mode_t;

    // One nibble of the mode register; timer one high, timer zero low
    typedef struct packed {
        logic gate;
        logic src;
        dtcu_mode_t mode;
    } dtcu_cfg_t;

    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } dtcu_count_t;

    typedef struct packed {
        dtcu_count_t count;
        logic ovf;
    } dtcu_step_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic [7:0] wdata;
    } dtcu_sfr_req_t;

endpackage

// File: hw/dtcu_pin_sampler.sv
// Pin synchroniser with per-machine-cycle sampling and fall detect
`timescale 1ns/1ps
`default_nettype none
module dtcu_pin_sampler (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic pin,
    input wire logic sample_stb,
    output logic level,
    output logic fall
);

    logic sync1_q;
    logic sync2_q;
    logic samp_q;
    logic fall_q;

    // ------------------------------------------------------------
    // Two-flop synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Sample once per machine cycle, flag high-then-low
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            samp_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            fall_q <= sample_stb & samp_q & ~sync2_q;
            if (sample_stb) begin
                samp_q <= sync2_q;
            end
        end
    end

    assign level = sync2_q;
    assign fall = fall_q;

endmodule
`default_nettype wire

// File: tb/dtcu_pin_model.sv
// Behavioural source for one external count pin
`timescale 1ns/1ps
`default_nettype none
module dtcu_pin_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [7:0] pulses,
    input wire logic [7:0] half_len,
    output logic count_pin,
    output logic busy
);
    logic [8:0] left_q;
    logic [7:0] tick_q;
    logic [7:0] hold;

    // Each level lasts at least one machine cycle
    assign hold = (half_len < 8'h0c) ? 8'h0c : half_len;

    // Idle high, so the first pulse starts with a fall
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_pin <= 1'b1;
            busy <= 1'b0;
            left_q <= '0;
            tick_q <= '0;
        end else if (start && !busy && pulses != 8'h00) begin
            busy <= 1'b1;
            left_q <= {pulses, 1'b0};
            tick_q <= '0;
        end else if (busy) begin
            if (tick_q == hold - 8'h01) begin
                tick_q <= '0;
                count_pin <= ~count_pin;
                left_q <= left_q - 9'h001;
                if (left_q == 9'h001) begin
                    busy <= 1'b0;
                end
            end else begin
                tick_q <= tick_q + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the dual timer/counter unit
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    dtcu_pkg::dtcu_sfr_req_t sfr_req = '0;
    logic [7:0] sfr_rdata;
    logic cnt_zero;
    logic cnt_one;
    logic busy_zero;
    logic busy_one;
    logic [1:0] gate_pin = 2'b00;
    logic [1:0] ack = 2'b00;
    logic [1:0] flag;
    logic start = 1'b0;
    logic [7:0] pulses = 8'h00;
    logic [7:0] regs [7] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90};
    int error_cnt = 0;
    int checked = 0;
    int cyc = 0;
    int t_beg;
    int t_end;

    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;

    dtcu_timer_unit uut (.ref_clk(ref_clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .count_pin_zero(cnt_zero), .count_pin_one(cnt_one), .gate_pin_zero(gate_pin[0]),
        .gate_pin_one(gate_pin[1]), .isr_ack_zero(ack[0]), .isr_ack_one(ack[1]),
        .timer_zero_overflow_flag(flag[0]), .timer_one_overflow_flag(flag[1]));
    dtcu_pin_model pin_zero (.ref_clk(ref_clk), .rst(rst), .start(start), .pulses(pulses),
        .half_len(8'h0c), .count_pin(cnt_zero), .busy(busy_zero));
    dtcu_pin_model pin_one (.ref_clk(ref_clk), .rst(rst), .start(start), .pulses(pulses),
        .half_len(8'h0c), .count_pin(cnt_one), .busy(busy_one));

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_rng(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        sfr_req <= '{addr: a, wr: 1'b1, wdata: d};
        @(posedge ref_clk);
        sfr_req.wr <= 1'b0;
    endtask

    task automatic chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        sfr_req <= '{addr: a, wr: 1'b0, wdata: 8'h00};
        @(posedge ref_clk);
        #1 cmp8(sfr_rdata, exp);
    endtask

    // Sel 0 or 1 waits for that flag, sel 2 for both pin sources idle
    task automatic wait_for(input int sel, input int lim, output int t);
        int n;
        for (n = 0; n < lim; n++) begin
            @(posedge ref_clk);
            #1;
            if (sel < 2 && flag[sel] === 1'b1) break;
            if (sel == 2 && (busy_zero | busy_one) === 1'b0) break;
        end
        t = cyc;
        if (n == lim) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, n, sel);
            print_verdict();
        end
    endtask

    task automatic pulse(input logic [7:0] n);
        @(posedge ref_clk);
        pulses <= n;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        @(posedge ref_clk);
        wait_for(2, 3000, t_end);
        repeat (36) @(posedge ref_clk);
    endtask

    task automatic run_from(input logic [7:0] d);
        wr(dtcu_pkg::ADDR_RUN_FLAG, d);
        #1 t_beg = cyc;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        foreach (regs[i]) chk(regs[i], 8'h00);
        wr(dtcu_pkg::ADDR_MODE, 8'ha5);
        chk(dtcu_pkg::ADDR_MODE, 8'ha5);
        wr(dtcu_pkg::ADDR_RUN_FLAG, 8'h0f);
        chk(dtcu_pkg::ADDR_RUN_FLAG, 8'h00);
        $display("test registers finished");

        wr(dtcu_pkg::ADDR_MODE, 8'h02);
        wr(dtcu_pkg::ADDR_ZERO_HIGH, 8'hf0);
        wr(dtcu_pkg::ADDR_ZERO_LOW, 8'hf0);
        run_from(8'h10);
        wait_for(0, 300, t_beg);
        @(posedge ref_clk) ack <= 2'b01;
        @(posedge ref_clk) ack <= 2'b00;
        @(posedge ref_clk);
        #1 cmp8({7'h00, flag[0]}, 8'h00);
        wait_for(0, 300, t_end);
        cmp_rng(t_end - t_beg, 192, 192);
        wr(dtcu_pkg::ADDR_RUN_FLAG, 8'h00);
        chk(dtcu_pkg::ADDR_ZERO_HIGH, 8'hf0);
        $display("test reload finished");

        wr(dtcu_pkg::ADDR_MODE, 8'h00);
        wr(dtcu_pkg::ADDR_ONE_HIGH, 8'hfe);
        wr(dtcu_pkg::ADDR_ONE_LOW, 8'he0);
        run_from(8'h50);
        wait_for(1, 800, t_end);
        cmp_rng(t_end - t_beg, 756, 770);
        $display("test prescaled finished");

        wr(dtcu_pkg::ADDR_RUN_FLAG, 8'h00);
        wr(dtcu_pkg::ADDR_MODE, 8'h01);
        wr(dtcu_pkg::ADDR_ZERO_HIGH, 8'hfe);
        wr(dtcu_pkg::ADDR_ZERO_LOW, 8'hf0);
        run_from(8'h10);
        wait_for(0, 3400, t_end);
        cmp_rng(t_end - t_beg, 3252, 3266);
        wr(dtcu_pkg::ADDR_RUN_FLAG, 8'h00);
        chk(dtcu_pkg::ADDR_ZERO_HIGH, 8'h00);
        $display("test wide finished");

        wr(dtcu_pkg::ADDR_MODE, 8'h30);
        wr(dtcu_pkg::ADDR_ONE_LOW, 8'h33);
        wr(dtcu_pkg::ADDR_ONE_HIGH, 8'h44);
        wr(dtcu_pkg::ADDR_RUN_FLAG, 8'h40);
        repeat (60) @(posedge ref_clk);
        chk(dtcu_pkg::ADDR_ONE_LOW, 8'h33);
        chk(dtcu_pkg::ADDR_ONE_HIGH, 8'h44);
        chk(dtcu_pkg::ADDR_RUN_FLAG, 8'h40);
        $display("test hold finished");

        wr(dtcu_pkg::ADDR_RUN_FLAG, 8'h00);
        wr(dtcu_pkg::ADDR_MODE, 8'hdd);
        for (int i = 2; i < 6; i++) wr(regs[i], 8'h00);
        wr(dtcu_pkg::ADDR_RUN_FLAG, 8'h50);
        pulse(8'h03);
        chk(dtcu_pkg::ADDR_ZERO_LOW, 8'h00);
        chk(dtcu_pkg::ADDR_ONE_LOW, 8'h00);
        @(posedge ref_clk) gate_pin <= 2'b11;
        pulse(8'h05);
        chk(dtcu_pkg::ADDR_ZERO_LOW, 8'h05);
        chk(dtcu_pkg::ADDR_ONE_LOW, 8'h05);
        $display("test counter finished");

        wr(dtcu_pkg::ADDR_RUN_FLAG, 8'h00);
        wr(dtcu_pkg::ADDR_MODE, 8'h03);
        wr(dtcu_pkg::ADDR_ZERO_LOW, 8'hff);
        wr(dtcu_pkg::ADDR_ZERO_HIGH, 8'hff);
        wr(dtcu_pkg::ADDR_ONE_LOW, 8'h00);
        wr(dtcu_pkg::ADDR_ONE_HIGH, 8'h00);
        run_from(8'h40);
        wait_for(1, 40, t_end);
        cmp_rng(t_end - t_beg, 0, 14);
        cmp8({7'h00, flag[0]}, 8'h00);
        chk(dtcu_pkg::ADDR_ZERO_LOW, 8'hff);
        @(posedge ref_clk) ack <= 2'b10;
        @(posedge ref_clk) ack <= 2'b00;
        @(posedge ref_clk);
        #1 cmp8({7'h00, flag[1]}, 8'h00);
        $display("test split finished");
        print_verdict();
    end
endmodule
`default_nettype wire
